// file: hdl/icl_pkg.sv
// Constants and types shared by the input current limit register bank
package icl_pkg;

	// Byte addresses on the serial bus
	localparam logic [7:0] ICL_ADDR_LIMIT_LO = 8'h0e;
	localparam logic [7:0] ICL_ADDR_LIMIT_HI = 8'h0f;
	localparam logic [7:0] ICL_ADDR_MAKER = 8'h2e;
	localparam logic [7:0] ICL_ADDR_PART = 8'h2f;

	// Limit register layout and reset value
	localparam logic [15:0] ICL_LIMIT_RESET = 16'h4100;
	localparam int ICL_CODE_W = 7;
	localparam int ICL_CODE_LSB = 8;
	localparam int ICL_RSVD_BIT = 7;
	localparam logic [7:0] ICL_LO_BYTE_VAL = 8'h00;

	// Defaults restored on adapter removal, per sense resistor
	localparam logic [6:0] ICL_DEF_CODE_10M = 7'h41;
	localparam logic [6:0] ICL_DEF_CODE_5M = 7'h20;

	// Decoded current in mA
	localparam int ICL_MA_W = 14;
	localparam logic [13:0] ICL_STEP_MA_10M = 14'h0032;
	localparam logic [13:0] ICL_STEP_MA_5M = 14'h0064;
	localparam logic [13:0] ICL_FLOOR_MA_10M = 14'h0032;
	localparam logic [13:0] ICL_FLOOR_MA_5M = 14'h0064;

	// Serial bus framing
	localparam logic [3:0] ICL_BITS_PER_BYTE = 4'h8;

	// Applied limit as seen by the regulation loop
	typedef struct packed {
		logic [6:0] code;
		logic [13:0] ma;
	} icl_limit_t;

	// Serial slave states
	typedef enum logic [2:0] {
		ICL_IDLE,
		ICL_ADDR,
		ICL_ADDR_ACK,
		ICL_WR,
		ICL_WR_ACK,
		ICL_RD,
		ICL_RD_ACK
	} icl_state_t;

endpackage : icl_pkg

// file: hdl/icl_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module icl_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Asynchronous pins in, filtered levels out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_q
);

	logic [WIDTH-1:0] ff1_q;
	logic [WIDTH-1:0] ff2_q;
	logic [WIDTH-1:0] ff3_q;
	logic [WIDTH-1:0] level_d;

	////////////////////////////////////////////////////////////////////////
	// A change counts only once stages two and three agree
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
		begin
			level_d[i] = (ff2_q[i] == ff3_q[i]) ? ff3_q[i] : level_q[i];
		end
	end

	// Stage one feeds only stage two
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ff1_q <= RST_VAL;
			ff2_q <= RST_VAL;
			ff3_q <= RST_VAL;
			level_q <= RST_VAL;
		end
		else
		begin
			ff1_q <= pin_in;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
			level_q <= level_d;
		end
	end

endmodule : icl_sync

// file: hdl/icl_regs.sv
// Input current limit and identification registers behind a serial slave
//
// What this block does
// - At 10 mohm, code bits weigh 50 mA for bit 0 up to 3200 mA.
// - At 10 mohm the limit spans 50 mA to 6350 mA in 50 mA steps.
// - At 10 mohm, code zero gives a 50 mA floor; others no offset.
// - Codes above the clamp boundary are ignored, not applied.
// - At 10 mohm default is 3.25 A, restored on adapter removal.
// - At 5 mohm, code zero gives a 100 mA floor only.
// - At 5 mohm default is 3.2 A, restored on adapter removal.
// - At 5 mohm the programmed value is a maximum, not typical.
// - External limit pin used unless disabled by bit or pin above 4 V.
// - Low byte is read-only zero; writes to it are ignored.
// - Read-only maker code sits at byte address 2Eh.
// - Read-only part code sits at byte address 2Fh.
`timescale 1ns/1ps
module icl_regs #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a,
	// Arbitrary identification values
	parameter logic [7:0] MAKER_CODE = 8'h5a,
	parameter logic [7:0] PART_CODE = 8'ha5,
	// Highest accepted code for each sense resistor
	parameter logic [6:0] MAX_CODE_10M = 7'h7f,
	parameter logic [6:0] MAX_CODE_5M = 7'h7f
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Serial bus pins, data is open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out_q,
	output logic sda_oe_q,
	// Core status and configuration
	input wire logic sense_resistor_select,
	input wire logic adapter_present,
	input wire logic external_limit_enable,
	input wire logic external_limit_pin_high,
	// Applied limit and loop selection
	output icl_pkg::icl_limit_t limit_q,
	output logic limit_is_max_q,
	output logic external_limit_active_q,
	output logic invalid_write_q
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Current in mA for a code and sense resistor choice
	function automatic logic [13:0] icl_decode(input logic [6:0] code,
		input logic sel);
		logic [13:0] step;
		step = sel ? icl_pkg::ICL_STEP_MA_5M : icl_pkg::ICL_STEP_MA_10M;
		if (code == 7'h00)
			icl_decode = sel ? icl_pkg::ICL_FLOOR_MA_5M
				: icl_pkg::ICL_FLOOR_MA_10M;
		else
			icl_decode = 14'({7'h00, code} * step);
	endfunction : icl_decode

	// Default code for the selected sense resistor
	function automatic logic [6:0] icl_default(input logic sel);
		icl_default = sel ? icl_pkg::ICL_DEF_CODE_5M
			: icl_pkg::ICL_DEF_CODE_10M;
	endfunction : icl_default

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0] pins_q;
	logic scl_s;
	logic sda_s;
	logic ext_high_s;

	icl_sync #(
		.WIDTH(3),
		.RST_VAL(3'b011)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({external_limit_pin_high, scl_in, sda_in}),
		.level_q(pins_q)
	);

	assign ext_high_s = pins_q[2];
	assign scl_s = pins_q[1];
	assign sda_s = pins_q[0];

	////////////////////////////////////////////////////////////////////////
	// State

	icl_pkg::icl_state_t state_q, state_d;
	logic scl_prev_q, scl_prev_d;
	logic sda_prev_q, sda_prev_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic rw_q, rw_d;
	logic first_q, first_d;
	logic acked_q, acked_d;
	logic [7:0] ptr_q, ptr_d;
	logic lo_seen_q, lo_seen_d;
	logic [6:0] code_q, code_d;
	logic adapter_prev_q, adapter_prev_d;
	logic init_q, init_d;
	logic sda_oe_d;
	logic invalid_d;
	icl_pkg::icl_limit_t limit_d;
	logic limit_is_max_d;
	logic ext_active_d;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [7:0] rd_byte;
	logic [6:0] max_code;

	// Bus events from filtered pins
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign max_code = sense_resistor_select ? MAX_CODE_5M : MAX_CODE_10M;

	////////////////////////////////////////////////////////////////////////
	// Read data multiplexer
	always_comb
	begin
		case (ptr_q)
			icl_pkg::ICL_ADDR_LIMIT_LO: rd_byte = icl_pkg::ICL_LO_BYTE_VAL;
			icl_pkg::ICL_ADDR_LIMIT_HI: rd_byte = {1'b0, code_q};
			icl_pkg::ICL_ADDR_MAKER: rd_byte = MAKER_CODE;
			icl_pkg::ICL_ADDR_PART: rd_byte = PART_CODE;
			default: rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Serial slave and limit register next state
	always_comb
	begin
		state_d = state_q;
		scl_prev_d = scl_s;
		sda_prev_d = sda_s;
		sh_d = sh_q;
		cnt_d = cnt_q;
		rw_d = rw_q;
		first_d = first_q;
		acked_d = acked_q;
		ptr_d = ptr_q;
		lo_seen_d = lo_seen_q;
		code_d = code_q;
		adapter_prev_d = adapter_present;
		init_d = 1'b1;
		sda_oe_d = sda_oe_q;
		invalid_d = 1'b0;

		if (start_det)
		begin
			// Repeated start also drops a half-written limit
			state_d = icl_pkg::ICL_ADDR;
			cnt_d = 4'h0;
			sda_oe_d = 1'b0;
			lo_seen_d = 1'b0;
		end
		else if (stop_det)
		begin
			state_d = icl_pkg::ICL_IDLE;
			sda_oe_d = 1'b0;
			lo_seen_d = 1'b0;
		end
		else
		begin
			case (state_q)
				icl_pkg::ICL_IDLE:
				begin
					sda_oe_d = 1'b0;
				end
				icl_pkg::ICL_ADDR, icl_pkg::ICL_WR:
				begin
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end
					else if (scl_fall && cnt_q == icl_pkg::ICL_BITS_PER_BYTE)
					begin
						cnt_d = 4'h0;
						if (state_q == icl_pkg::ICL_ADDR)
						begin
							// Only our address is acknowledged
							if (sh_q[7:1] == SLAVE_ADDR)
							begin
								rw_d = sh_q[0];
								sda_oe_d = 1'b1;
								state_d = icl_pkg::ICL_ADDR_ACK;
							end
							else
								state_d = icl_pkg::ICL_IDLE;
						end
						else
						begin
							sda_oe_d = 1'b1;
							state_d = icl_pkg::ICL_WR_ACK;
							if (first_q)
							begin
								ptr_d = sh_q;
								first_d = 1'b0;
							end
							else
							begin
								ptr_d = ptr_q + 8'h01;
								lo_seen_d = (ptr_q == icl_pkg::ICL_ADDR_LIMIT_LO);
								if (ptr_q == icl_pkg::ICL_ADDR_LIMIT_HI && lo_seen_q)
								begin
									// Reserved bit set or code past clamp: keep old
									if (sh_q[icl_pkg::ICL_RSVD_BIT] ||
										sh_q[6:0] > max_code)
										invalid_d = 1'b1;
									else
										code_d = sh_q[6:0];
								end
							end
						end
					end
				end
				icl_pkg::ICL_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						cnt_d = 4'h0;
						if (rw_q)
						begin
							sh_d = rd_byte;
							sda_oe_d = ~rd_byte[7];
							state_d = icl_pkg::ICL_RD;
						end
						else
						begin
							sda_oe_d = 1'b0;
							first_d = 1'b1;
							state_d = icl_pkg::ICL_WR;
						end
					end
				end
				icl_pkg::ICL_WR_ACK:
				begin
					if (scl_fall)
					begin
						sda_oe_d = 1'b0;
						state_d = icl_pkg::ICL_WR;
					end
				end
				icl_pkg::ICL_RD:
				begin
					if (scl_rise)
						cnt_d = cnt_q + 4'h1;
					else if (scl_fall)
					begin
						if (cnt_q == icl_pkg::ICL_BITS_PER_BYTE)
						begin
							sda_oe_d = 1'b0;
							ptr_d = ptr_q + 8'h01;
							state_d = icl_pkg::ICL_RD_ACK;
						end
						else
						begin
							sh_d = {sh_q[6:0], 1'b0};
							sda_oe_d = ~sh_q[6];
						end
					end
				end
				icl_pkg::ICL_RD_ACK:
				begin
					if (scl_rise)
						acked_d = ~sda_s;
					else if (scl_fall)
					begin
						cnt_d = 4'h0;
						if (acked_q)
						begin
							sh_d = rd_byte;
							sda_oe_d = ~rd_byte[7];
							state_d = icl_pkg::ICL_RD;
						end
						else
							state_d = icl_pkg::ICL_IDLE;
					end
				end
				default:
				begin
					state_d = icl_pkg::ICL_IDLE;
					sda_oe_d = 1'b0;
				end
			endcase
		end

		// Default load after reset and on adapter removal wins over a write
		if (!init_q || (adapter_prev_q && !adapter_present))
			code_d = icl_default(sense_resistor_select);

		// Outputs follow the next code so they change on the same edge as code_q
		limit_d.code = code_d;
		limit_d.ma = icl_decode(code_d, sense_resistor_select);
		limit_is_max_d = sense_resistor_select;
		ext_active_d = external_limit_enable & ~ext_high_s;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= icl_pkg::ICL_IDLE;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			acked_q <= 1'b0;
			ptr_q <= 8'h00;
			lo_seen_q <= 1'b0;
			code_q <= icl_pkg::ICL_LIMIT_RESET[14:8];
			adapter_prev_q <= 1'b0;
			init_q <= 1'b0;
			sda_out_q <= 1'b0;
			sda_oe_q <= 1'b0;
			invalid_write_q <= 1'b0;
			limit_q <= '0;
			limit_is_max_q <= 1'b0;
			external_limit_active_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			scl_prev_q <= scl_prev_d;
			sda_prev_q <= sda_prev_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			rw_q <= rw_d;
			first_q <= first_d;
			acked_q <= acked_d;
			ptr_q <= ptr_d;
			lo_seen_q <= lo_seen_d;
			code_q <= code_d;
			adapter_prev_q <= adapter_prev_d;
			init_q <= init_d;
			sda_out_q <= 1'b0;
			sda_oe_q <= sda_oe_d;
			invalid_write_q <= invalid_d;
			limit_q <= limit_d;
			limit_is_max_q <= limit_is_max_d;
			external_limit_active_q <= ext_active_d;
		end
	end

endmodule : icl_regs

// file: verif/icl_regs_monitor.sv
// Port checker for the input current limit register bank
`timescale 1ns/1ps
module icl_regs_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out_q,
	input wire logic sda_oe_q,
	// Core side
	input wire logic sense_resistor_select,
	input wire logic adapter_present,
	input wire logic external_limit_enable,
	input wire logic external_limit_pin_high,
	input wire icl_pkg::icl_limit_t limit_q,
	input wire logic limit_is_max_q,
	input wire logic external_limit_active_q,
	input wire logic invalid_write_q
);
	logic [1:0] up_q;
	logic [1:0] up_d;
	logic [13:0] cw;
	logic [13:0] m10;
	logic [13:0] m5;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	//////////////////////////////
	// Outputs still show reset values until the first edge after release
	always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
	always_ff @(posedge clk) up_q <= sys_rst ? 2'h0 : up_d;
	// Expected decode; floor equals one step, so code zero maps to it
	assign cw = 14'(limit_q.code);
	assign m10 = (cw == 14'h0000) ? 14'h0032 : cw * 14'h0032;
	assign m5 = (cw == 14'h0000) ? 14'h0064 : cw * 14'h0064;
	property p_w10;
		up_q == 2'h3 && !limit_is_max_q && $stable(limit_is_max_q)
			|-> limit_q.ma == m10;
	endproperty
	a_w10: assert property (p_w10) else $error("bad mA, 10 mohm");
	property p_w5;
		up_q == 2'h3 && limit_is_max_q && $stable(limit_is_max_q)
			|-> limit_q.ma == m5;
	endproperty
	a_w5: assert property (p_w5) else $error("bad mA, 5 mohm");
	property p_max;
		up_q == 2'h3 |-> limit_is_max_q == $past(sense_resistor_select);
	endproperty
	a_max: assert property (p_max) else $error("max flag wrong");
	property p_ext;
		!external_limit_enable |=> !external_limit_active_q;
	endproperty
	a_ext: assert property (p_ext) else $error("ext loop not off");
	property p_pin;
		external_limit_pin_high [*8] |=> !external_limit_active_q;
	endproperty
	a_pin: assert property (p_pin) else $error("pin high ignored");
	property p_rem;
		$fell(adapter_present) |->
			##2 limit_q.code == (limit_is_max_q ? 7'h20 : 7'h41);
	endproperty
	a_rem: assert property (p_rem) else $error("no default");
	// A rejected write must pulse once and leave the code alone
	property p_inv;
		invalid_write_q |=> !invalid_write_q ##0 $stable(limit_q.code) [*3];
	endproperty
	a_inv: assert property (p_inv) else $error("bad write applied");
	// Host changes land only inside a byte's ACK, with the clock low
	property p_chg;
		up_q == 2'h3 && $changed(limit_q.code) && $past(adapter_present)
			&& $past(adapter_present, 2) |-> !scl_in;
	endproperty
	a_chg: assert property (p_chg) else $error("code changed mid bit");
	c_inv: cover property (invalid_write_q);
	c_rem: cover property ($fell(adapter_present));
	c_ext: cover property ($rose(external_limit_active_q));
endmodule : icl_regs_monitor
bind icl_regs icl_regs_monitor u_mon (.*);

// file: verif/icl_host_model.sv
// Serial bus host model driving the register bank pins
`timescale 1ns/1ps
module icl_host_model (
	// Clock
	input wire logic clk,
	// Device pull-down on the data wire
	input wire logic sda_oe_q,
	// Wire levels
	output logic scl,
	output wire logic sda
);
	int half = 10;
	logic pull_q = 1'b0;
	//////////////////////////////
	// Open drain data wire with pull-up; idle clock stands high
	assign sda = ~(pull_q | sda_oe_q);
	initial scl = 1'b1;
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	// Start (0,1) or stop (1,0): data is set first, then moves while the clock is high
	task automatic cond(input logic a, input logic b);
		w(half / 2);
		pull_q = a;
		w(half / 2);
		scl = 1'b1;
		w(half);
		pull_q = b;
		w(half);
		scl = ~b;
	endtask : cond
	// Data set mid low phase, far from edges the device filters
	task automatic bit_x(input logic b, output logic v);
		w(half / 2);
		pull_q = ~b;
		w(half / 2);
		scl = 1'b1;
		w(half);
		v = sda;
		scl = 1'b0;
	endtask : bit_x
	task automatic byte_x(input logic [8:0] d, output logic [8:0] v);
		for (int i = 8; i >= 0; i--)
			bit_x(d[i], v[i]);
	endtask : byte_x
endmodule : icl_host_model

// file: verif/icl_regs_tb_top.sv
// Self-checking bench for the input current limit register bank
`timescale 1ns/1ps
module icl_regs_tb_top;
	localparam logic [6:0] SA = 7'h2a;
	logic clk, sys_rst, sel, adp, ext_en, ext_hi, scl, sda;
	logic sda_out_q, sda_oe_q, lim_max, ext_act, inv;
	icl_pkg::icl_limit_t lim;
	logic [8:0] r;
	logic [6:0] c, code_q;
	logic [6:0] corner [8] = '{7'h00, 7'h00, 7'h7f, 7'h7f, 7'h65, 7'h64,
		7'h64, 7'h65};
	int n_checks = 0;
	int num_errors = 0;
	int n_inv = 0;
	// Rejected high byte writes seen since the last clear
	always @(posedge clk)
	begin
		if (inv)
			n_inv++;
	end
	//////////////////////////////
	// Clamp lowered at 10 mohm so the boundary can be reached
	icl_regs #(.MAX_CODE_10M(7'h64)) dut (.clk(clk), .sys_rst(sys_rst),
		.scl_in(scl), .sda_in(sda), .sda_out_q(sda_out_q),
		.sda_oe_q(sda_oe_q), .sense_resistor_select(sel),
		.adapter_present(adp), .external_limit_enable(ext_en),
		.external_limit_pin_high(ext_hi), .limit_q(lim),
		.limit_is_max_q(lim_max), .external_limit_active_q(ext_act),
		.invalid_write_q(inv));
	icl_host_model host (.clk(clk), .sda_oe_q(sda_oe_q), .scl(scl),
		.sda(sda));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string s, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
		end
	endtask : chk
	function automatic logic [13:0] ma(input logic [6:0] k, input logic s);
		logic [13:0] st;
		st = s ? 14'h0064 : 14'h0032;
		return (k == 7'h00) ? st : 14'(k) * st;
	endfunction : ma
	// Host side maximum: nominal plus the sense dependent offset
	function automatic logic [15:0] imax(input logic [6:0] k, input logic s);
		return 16'(ma(k, s)) + (s ? 16'h00c8 : 16'h0064);
	endfunction : imax
	// Pointer then n data bytes, upper half of d first
	task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
		host.cond(1'b0, 1'b1);
		host.byte_x({SA, 2'b01}, r);
		chk("ack", 16'(r[0]), 16'h0000);
		host.byte_x({p, 1'b1}, r);
		for (int i = 0; i < n; i++)
			host.byte_x({d[15 - 8 * i -: 8], 1'b1}, r);
		host.cond(1'b1, 1'b0);
	endtask : wr
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		wr(p, 16'h0000, 0);
		host.cond(1'b0, 1'b1);
		host.byte_x({SA, 2'b11}, r);
		host.byte_x(9'h1ff, r);
		host.cond(1'b1, 1'b0);
		chk("read", 16'(r[8:1]), 16'(e));
	endtask : rd
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	// Watchdog against a hung run
	initial
	begin
		repeat (90000) @(posedge clk);
		num_errors++;
		final_report();
	end
	// Main sequence, inputs move on falling edges
	initial
	begin
		sys_rst = 1'b1;
		sel = 1'b0;
		adp = 1'b1;
		ext_en = 1'b0;
		ext_hi = 1'b0;
		code_q = 7'h41;
		c = 7'($urandom(32'h0000_625b));
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge clk);
		chk("ma", 16'(lim.ma), 16'h0cb2);
		chk("sda out", 16'(sda_out_q), 16'h0000);
		rd(8'h0f, 8'h41);
		rd(8'h2e, 8'h5a);
		rd(8'h2f, 8'ha5);
		rd(8'h30, 8'h00);
		// Corner codes with a prompt host, then random ones with a slow host
		for (int i = 0; i < 14; i++)
		begin
			c = (i < 8) ? corner[i] : 7'($urandom);
			sel = (i < 8) ? i[0] : 1'($urandom);
			host.half = (i < 8) ? 10 : 16;
			n_inv = 0;
			wr(8'h0e, {8'($urandom), i == 9, c}, 2);
			chk("inv", 16'(n_inv), 16'(i == 9 || c > (sel ? 7'h7f : 7'h64)));
			if (i != 9 && c <= (sel ? 7'h7f : 7'h64))
				code_q = c;
			chk("code", 16'(lim.code), 16'(code_q));
			chk("ma", 16'(lim.ma), 16'(ma(code_q, sel)));
			chk("max", 16'(lim_max), 16'(sel));
			chk("imax", 16'(lim.ma) + (sel ? 16'h00c8 : 16'h0064), imax(code_q, sel));
			rd(8'h0f, {1'b0, code_q});
		end
		rd(8'h0e, 8'h00);
		// Upper byte alone must not take effect
		wr(8'h0f, 16'h0500, 1);
		chk("half", 16'(lim.code), 16'(code_q));
		for (int s = 0; s < 2; s++)
		begin
			sel = s[0];
			adp = 1'b0;
			repeat (4) @(negedge clk);
			chk("def", 16'(lim.code), s ? 16'h0020 : 16'h0041);
			chk("def ma", 16'(lim.ma), s ? 16'h0c80 : 16'h0cb2);
			adp = 1'b1;
			wr(8'h0e, 16'h0001, 2);
		end
		for (int k = 0; k < 4; k++)
		begin
			ext_en = k[0];
			ext_hi = k[1];
			repeat (10) @(negedge clk);
			chk("ext", 16'(ext_act), 16'(k == 1));
		end
		final_report();
	end
endmodule : icl_regs_tb_top
